// ==== rtl/ptcr_pkg.sv ====
// Package: register map, field layout and reset values of the time config bank
package ptcr_pkg;
    localparam int PTCR_NUM_PINS = 12;
    localparam int PTCR_ADR_W = 10;
    localparam int PTCR_NS_W = 32;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_SFD_ROUTE = 8'h19;
    localparam logic [7:0] IDX_IRQ_ROUTE = 8'h1a;
    localparam logic [7:0] IDX_REF_CLOCK = 8'h1b;
    localparam logic [7:0] IDX_ETHERTYPE = 8'h1c;
    localparam logic [7:0] IDX_MSG_OFFSET = 8'h1d;
    localparam logic [7:0] IDX_PIN_MONITOR = 8'h1e;
    localparam logic [7:0] IDX_ID_FILTER = 8'h1f;

    localparam logic [9:0] ADR_SFD_ROUTE = {IDX_SFD_ROUTE, 2'b00};
    localparam logic [9:0] ADR_IRQ_ROUTE = {IDX_IRQ_ROUTE, 2'b00};
    localparam logic [9:0] ADR_REF_CLOCK = {IDX_REF_CLOCK, 2'b00};
    localparam logic [9:0] ADR_ETHERTYPE = {IDX_ETHERTYPE, 2'b00};
    localparam logic [9:0] ADR_MSG_OFFSET = {IDX_MSG_OFFSET, 2'b00};
    localparam logic [9:0] ADR_PIN_MONITOR = {IDX_PIN_MONITOR, 2'b00};
    localparam logic [9:0] ADR_ID_FILTER = {IDX_ID_FILTER, 2'b00};

    // Field positions
    localparam int TX_SEL_LSB = 4;
    localparam int RX_SEL_LSB = 0;
    localparam int SRC_CODE_LSB = 14;
    localparam int DIV_N_LSB = 3;
    localparam int HASH_EN_BIT = 12;

    // Reset values
    localparam logic [3:0] PIN_SEL_RST = 4'h0;
    localparam logic [1:0] SRC_CODE_RST = 2'h0;
    localparam logic [6:0] PERIOD_RST = 7'h00;
    localparam logic [15:0] ETHERTYPE_RST = 16'hf788;
    localparam logic [11:0] HASH_RST = 12'h000;
    localparam logic [7:0] OFFSET_RST = 8'h00;

    localparam logic [6:0] PERIOD_MIN = 7'h08;

    // Reference source codes; any code with the top bit set is external
    localparam logic [1:0] SRC_PHASE_GEN = 2'h0;
    localparam logic [1:0] SRC_PHASE_DIV = 2'h1;
endpackage

// ==== rtl/ptcr_ref_if.sv ====
// Interface: reference source control between the bank and the tick generator
`timescale 1ns/100ps
interface ptcr_ref_if;
    logic [1:0] refSourceCode;
    logic [3:0] divisorN;
    logic refTick;
    modport ctrl (output refSourceCode, output divisorN, input refTick);
    modport gen (input refSourceCode, input divisorN, output refTick);
endinterface

// ==== rtl/ptcr_ref_tick.sv ====
// Module: reference clock tick selection and divide-by-N
`timescale 1ns/100ps
module ptcr_ref_tick
    import ptcr_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic phaseGenTick,
    input wire logic extRefTick,
    ptcr_ref_if.gen refPort
);
    logic [3:0] divCnt_ff;
    logic [3:0] nxt_divCnt;
    logic refTick_ff;
    logic nxt_refTick;
    logic divWrap;

    // N of 0 or 1 passes every phase generator tick
    assign divWrap = (divCnt_ff + 4'h1 >= refPort.divisorN);
    assign nxt_divCnt = (refPort.refSourceCode != SRC_PHASE_DIV) ? 4'h0 :
                        !phaseGenTick ? divCnt_ff :
                        divWrap ? 4'h0 : divCnt_ff + 4'h1;
    assign nxt_refTick = refPort.refSourceCode[1] ? extRefTick :
                         (refPort.refSourceCode == SRC_PHASE_DIV) ?
                         (phaseGenTick & divWrap) : phaseGenTick; // R05 R07

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            divCnt_ff <= 4'h0;
            refTick_ff <= 1'b0;
        end else begin
            divCnt_ff <= nxt_divCnt;
            refTick_ff <= nxt_refTick;
        end
    end

    assign refPort.refTick = refTick_ff;
endmodule // ptcr_ref_tick

// ==== rtl/ptcr_bank.sv ====
// Module: time protocol pin routing, reference clock and parser config bank
// Behaviour
// R01: Transmit delimiter pulse goes to pin picked by selector 7:4; zero disables.
// R02: Receive delimiter pulse goes to pin picked by selector 3:0; zero disables.
// R03: Several functions may share one pin; no setting is refused.
// R04: Interrupt goes to pin picked by 4-bit selector; zero disables all. Zero here disables only the interrupt; delimiter pulses keep their pins.
// R05: Source code 00 phase generator, 01 divided generator, 1x external.
// R06: Period below 8 written stores 8 instead.
// R07: Divided source uses period bits 6:3 as N, ignores 2:0.
// R08: Nanosecond counter adds the period on every reference tick.
// R09: Frame type compared with programmable Ethertype, reset f788.
// R10: Read-only 8-bit field reports time message byte offset.
// R11: Read-only 12-bit field shows live pin inputs, pin 1 in bit 0.
// R12: With hash enabled, deliver receive timestamp only on hash match.
// R13: Hash result never blocks timestamp insertion.
// R14: Reserved bits ignore writes and read zero.
// R15: Selector values 13 to 15 drive no pin.
//
// Our own choice: register access over Wishbone.
`timescale 1ns/100ps
module ptcr_bank
    import ptcr_pkg::*;
#(
    parameter int NS_W = PTCR_NS_W
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [PTCR_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic txSfdPulse,
    input wire logic rxSfdPulse,
    input wire logic ptpIrq,
    output logic [PTCR_NUM_PINS-1:0] gpioOut,
    input wire logic [PTCR_NUM_PINS-1:0] pinInputLevels,
    input wire logic phaseGenTick,
    input wire logic extRefTick,
    output logic [NS_W-1:0] nsCount,
    input wire logic frameTypeValid,
    input wire logic [15:0] frameType,
    output logic l2TypeMatch,
    input wire logic msgOffsetValid,
    input wire logic [7:0] msgOffset,
    input wire logic rxTsCandidate,
    input wire logic [11:0] srcIdHash,
    output logic rxTsDeliver,
    input wire logic tsInsertReq,
    output logic tsInsertGo
);
    // Selector to pin mask; 0 and 13..15 give no pin
    function automatic logic [PTCR_NUM_PINS-1:0] pinDecode(
        input logic [3:0] sel
    );
        logic [PTCR_NUM_PINS-1:0] mask;
        mask = '0;
        if (sel != 4'h0 && sel <= 4'(PTCR_NUM_PINS)) begin
            mask[sel - 4'h1] = 1'b1; // R15
        end
        return mask;
    endfunction

    ptcr_ref_if refBus ();

    logic [3:0] txPinSel_ff;
    logic [3:0] rxPinSel_ff;
    logic [3:0] irqPinSel_ff;
    logic [1:0] refSourceCode_ff;
    logic [6:0] refPeriodNs_ff;
    logic [15:0] l2TypeMatch_ff;
    logic [7:0] msgByteOffset_ff;
    logic hashEnable_ff;
    logic [11:0] identityExpected_ff;
    logic ack_ff;
    logic [31:0] rdData_ff;
    logic [PTCR_NUM_PINS-1:0] gpioOut_ff;
    logic [NS_W-1:0] nsCount_ff;
    logic typeHit_ff;
    logic rxTsDeliver_ff;
    logic tsInsertGo_ff;

    // Bus decode
    wire busReq = wb_cyc_i & wb_stb_i;
    wire wrStrobe = busReq & wb_we_i & ack_ff;
    wire lane0 = wb_sel_i[0];
    wire lane1 = wb_sel_i[1];
    wire hitSfd = (wb_adr_i == ADR_SFD_ROUTE);
    wire hitIrq = (wb_adr_i == ADR_IRQ_ROUTE);
    wire hitClk = (wb_adr_i == ADR_REF_CLOCK);
    wire hitEtr = (wb_adr_i == ADR_ETHERTYPE);
    wire hitOff = (wb_adr_i == ADR_MSG_OFFSET);
    wire hitMon = (wb_adr_i == ADR_PIN_MONITOR);
    wire hitHash = (wb_adr_i == ADR_ID_FILTER);

    // Read views; reserved bits are zero
    wire [15:0] viewSfd = {8'h00, txPinSel_ff, rxPinSel_ff}; // R14
    wire [15:0] viewIrq = {12'h000, irqPinSel_ff}; // R14
    wire [15:0] viewClk = {refSourceCode_ff, 7'h00, refPeriodNs_ff}; // R14
    wire [15:0] viewOff = {8'h00, msgByteOffset_ff}; // R10
    wire [15:0] viewMon = {4'h0, pinInputLevels}; // R11
    wire [15:0] viewHash = {3'h0, hashEnable_ff, identityExpected_ff};
    wire [15:0] readMux = hitSfd ? viewSfd :
                          hitIrq ? viewIrq :
                          hitClk ? viewClk :
                          hitEtr ? l2TypeMatch_ff :
                          hitOff ? viewOff :
                          hitMon ? viewMon :
                          hitHash ? viewHash : 16'h0000;

    // Period write with floor
    wire [6:0] periodWr = wb_dat_i[6:0];
    wire [6:0] periodClamped = (periodWr < PERIOD_MIN) ?
                               PERIOD_MIN : periodWr; // R06

    // Pin routing, functions OR together on shared pins
    wire [PTCR_NUM_PINS-1:0] txMask = pinDecode(txPinSel_ff); // R01
    wire [PTCR_NUM_PINS-1:0] rxMask = pinDecode(rxPinSel_ff); // R02
    wire [PTCR_NUM_PINS-1:0] irqMask = pinDecode(irqPinSel_ff); // R04
    logic [PTCR_NUM_PINS-1:0] nxt_gpioOut;
    genvar gi;
    generate
        for (gi = 0; gi < PTCR_NUM_PINS; gi = gi + 1) begin : gPin
            assign nxt_gpioOut[gi] = (txMask[gi] & txSfdPulse) |
                                     (rxMask[gi] & rxSfdPulse) |
                                     (irqMask[gi] & ptpIrq); // R03
        end
    endgenerate

    // Parser side
    wire nxt_typeHit = frameTypeValid &
                       (frameType == l2TypeMatch_ff); // R09
    wire hashOk = !hashEnable_ff |
                  (srcIdHash == identityExpected_ff); // R12
    wire nxt_rxTsDeliver = rxTsCandidate & hashOk; // R12
    wire [NS_W-1:0] nxt_nsCount = refBus.refTick ?
                                  nsCount_ff + NS_W'(refPeriodNs_ff) :
                                  nsCount_ff; // R08

    // Tick generator controls
    assign refBus.refSourceCode = refSourceCode_ff; // R05
    assign refBus.divisorN = refPeriodNs_ff[6:DIV_N_LSB]; // R07

    ptcr_ref_tick uRefTick (
        .mclk(mclk),
        .rst_b(rst_b),
        .phaseGenTick(phaseGenTick),
        .extRefTick(extRefTick),
        .refPort(refBus.gen)
    );

    // Bus slave: ack one cycle after request, write at acked edge
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            ack_ff <= 1'b0;
            rdData_ff <= 32'h0000_0000;
        end else begin
            ack_ff <= busReq & !ack_ff;
            rdData_ff <= (busReq & !ack_ff & !wb_we_i) ?
                         {16'h0000, readMux} : 32'h0000_0000;
        end
    end

    // Routing registers
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            txPinSel_ff <= PIN_SEL_RST;
            rxPinSel_ff <= PIN_SEL_RST;
            irqPinSel_ff <= PIN_SEL_RST;
        end else begin
            if (wrStrobe & hitSfd & lane0) begin
                txPinSel_ff <= wb_dat_i[TX_SEL_LSB +: 4]; // R01
                rxPinSel_ff <= wb_dat_i[RX_SEL_LSB +: 4]; // R02
            end
            if (wrStrobe & hitIrq & lane0) begin
                irqPinSel_ff <= wb_dat_i[3:0]; // R04
            end
        end
    end

    // Reference clock register
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            refSourceCode_ff <= SRC_CODE_RST;
            refPeriodNs_ff <= PERIOD_RST;
        end else begin
            if (wrStrobe & hitClk & lane1) begin
                refSourceCode_ff <= wb_dat_i[SRC_CODE_LSB +: 2]; // R05
            end
            if (wrStrobe & hitClk & lane0) begin
                refPeriodNs_ff <= periodClamped; // R06
            end
        end
    end

    // Ethertype and hash filter registers
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            l2TypeMatch_ff <= ETHERTYPE_RST;
            hashEnable_ff <= 1'b0;
            identityExpected_ff <= HASH_RST;
        end else begin
            if (wrStrobe & hitEtr & lane0) begin
                l2TypeMatch_ff[7:0] <= wb_dat_i[7:0]; // R09
            end
            if (wrStrobe & hitEtr & lane1) begin
                l2TypeMatch_ff[15:8] <= wb_dat_i[15:8]; // R09
            end
            if (wrStrobe & hitHash & lane0) begin
                identityExpected_ff[7:0] <= wb_dat_i[7:0];
            end
            if (wrStrobe & hitHash & lane1) begin
                identityExpected_ff[11:8] <= wb_dat_i[11:8];
                hashEnable_ff <= wb_dat_i[HASH_EN_BIT]; // R12
            end
        end
    end

    // Offset reported by the parser, read-only to software
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            msgByteOffset_ff <= OFFSET_RST;
        end else if (msgOffsetValid) begin
            msgByteOffset_ff <= msgOffset; // R10
        end
    end

    // Datapath outputs
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            gpioOut_ff <= '0;
            nsCount_ff <= '0;
            typeHit_ff <= 1'b0;
            rxTsDeliver_ff <= 1'b0;
            tsInsertGo_ff <= 1'b0;
        end else begin
            gpioOut_ff <= nxt_gpioOut;
            nsCount_ff <= nxt_nsCount;
            typeHit_ff <= nxt_typeHit;
            rxTsDeliver_ff <= nxt_rxTsDeliver;
            tsInsertGo_ff <= tsInsertReq; // R13
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdData_ff;
    assign gpioOut = gpioOut_ff;
    assign nsCount = nsCount_ff;
    assign l2TypeMatch = typeHit_ff;
    assign rxTsDeliver = rxTsDeliver_ff;
    assign tsInsertGo = tsInsertGo_ff;
endmodule // ptcr_bank

// ==== verif/ptcr_bank_chk.sv ====
// Checker: concurrent assertions on the time config bank ports
`timescale 1ns/100ps
module ptcr_bank_chk
    import ptcr_pkg::*;
#(
    parameter int NS_W = PTCR_NS_W
) (
    input logic mclk,
    input logic rst_b,
    input logic wb_we_i,
    input logic [PTCR_ADR_W-1:0] wb_adr_i,
    input logic [31:0] wb_dat_o,
    input logic wb_ack_o,
    input logic txSfdPulse,
    input logic rxSfdPulse,
    input logic ptpIrq,
    input logic [PTCR_NUM_PINS-1:0] gpioOut,
    input logic [PTCR_NUM_PINS-1:0] pinInputLevels,
    input logic phaseGenTick,
    input logic extRefTick,
    input logic [NS_W-1:0] nsCount,
    input logic frameTypeValid,
    input logic l2TypeMatch,
    input logic rxTsCandidate,
    input logic rxTsDeliver,
    input logic tsInsertReq,
    input logic tsInsertGo
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    chk_insert_follows: assert property (tsInsertReq |=> tsInsertGo)
        else $error("insert request not passed on");
    chk_deliver_cause: assert property (!rxTsCandidate |=> !rxTsDeliver)
        else $error("timestamp delivered without candidate");
    chk_match_cause: assert property (!frameTypeValid |=> !l2TypeMatch)
        else $error("type match without valid frame type");
    chk_pins_quiet: assert property
        (!(txSfdPulse || rxSfdPulse || ptpIrq) |=> gpioOut == '0)
        else $error("pin driven with nothing routed");
    chk_ns_hold: assert property
        (!$past(phaseGenTick, 2) && !$past(extRefTick, 2) |-> $stable(nsCount))
        else $error("counter moved without tick");
    chk_monitor_live: assert property
        (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == ADR_PIN_MONITOR
        |-> wb_dat_o[15:0] == {4'h0, $past(pinInputLevels)})
        else $error("monitor read wrong");
    chk_upper_zero: assert property (wb_dat_o[31:16] == 16'h0000)
        else $error("unused read bits set");
    chk_period_floor: assert property
        (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == ADR_REF_CLOCK
        |-> wb_dat_o[13:7] == 7'h00
        && (wb_dat_o[6:0] == 7'h00 || wb_dat_o[6:0] >= PERIOD_MIN))
        else $error("reference register read wrong");
endmodule // ptcr_bank_chk

bind ptcr_bank ptcr_bank_chk #(.NS_W(NS_W)) ptcr_bank_chk_i (.mclk, .rst_b,
    .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .txSfdPulse, .rxSfdPulse,
    .ptpIrq, .gpioOut, .pinInputLevels, .phaseGenTick, .extRefTick, .nsCount,
    .frameTypeValid, .l2TypeMatch, .rxTsCandidate, .rxTsDeliver, .tsInsertReq,
    .tsInsertGo);

// ==== verif/ptcr_bank_tb.sv ====
// Testbench: registers, routing, filters and time counter of the bank
`timescale 1ns/100ps
module ptcr_bank_tb;
    import ptcr_pkg::*;
    logic mclk = 1'b0, rst_b = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0, wb_ack_o, l2TypeMatch, rxTsDeliver, tsInsertGo;
    logic [9:0] wb_adr_i = 10'h000;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, nsCount;
    logic txSfdPulse = 1'b0, rxSfdPulse = 1'b0, ptpIrq = 1'b0;
    logic phaseGenTick = 1'b0, extRefTick = 1'b0, frameTypeValid = 1'b0;
    logic msgOffsetValid = 1'b0, rxTsCandidate = 1'b0, tsInsertReq = 1'b0;
    logic [11:0] gpioOut, pinInputLevels = 12'h000, srcIdHash = 12'h000;
    logic [15:0] frameType = 16'h0;
    logic [7:0] msgOffset = 8'h00;
    logic [11:0] sel, h, lv;
    logic [15:0] t;
    logic [2:0] p;
    int errCount = 0, testsRun = 0;
    logic [9:0] adrTab [8] = '{ADR_SFD_ROUTE, ADR_IRQ_ROUTE, ADR_REF_CLOCK,
        ADR_ETHERTYPE, ADR_MSG_OFFSET, ADR_PIN_MONITOR, ADR_ID_FILTER, 10'h3fc};
    logic [15:0] rstTab [8] = '{0, 0, 0, 16'hf788, 0, 0, 0, 0};
    logic [15:0] oneTab [8] = '{16'h00ff, 16'h000f, 16'hc07f, 16'hffff, 0, 0,
        16'h1fff, 0};

    ptcr_bank ptcr_bank_i (.mclk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .txSfdPulse,
        .rxSfdPulse, .ptpIrq, .gpioOut, .pinInputLevels, .phaseGenTick,
        .extRefTick, .nsCount, .frameTypeValid, .frameType, .l2TypeMatch,
        .msgOffsetValid, .msgOffset, .rxTsCandidate, .srcIdHash, .rxTsDeliver,
        .tsInsertReq, .tsInsertGo);

    always #5 mclk = ~mclk;

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        testsRun++;
        if (got !== exp) begin
            errCount++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wbAccess(input logic w, input logic [9:0] a,
            input logic [31:0] d, output logic [31:0] q);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_sel_i <= 4'h3;
        wb_dat_i <= d;
        @(posedge mclk);
        while (wb_ack_o !== 1'b1) begin
            @(posedge mclk);
        end
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        logic [31:0] q;
        wbAccess(1'b1, a, d, q);
    endtask

    task automatic rdChk(input logic [9:0] a, input logic [31:0] exp);
        logic [31:0] q;
        wbAccess(1'b0, a, 32'h0, q);
        check(q, exp);
    endtask

    task automatic step;
        @(posedge mclk);
        {txSfdPulse, rxSfdPulse, ptpIrq, frameTypeValid} <= 4'h0;
        {msgOffsetValid, rxTsCandidate, tsInsertReq} <= 3'h0;
        {phaseGenTick, extRefTick} <= 2'h0;
        #1;
    endtask

    function automatic logic [11:0] pinOf(input logic [3:0] s, input logic on);
        pinOf = (on && s >= 1 && s <= 12) ? 12'h001 << (s - 1) : 12'h000;
    endfunction

    task automatic tickRun(input logic [15:0] cfg, input int nPh,
            input int nEx, input logic [31:0] inc);
        logic [31:0] base;
        wr(ADR_REF_CLOCK, {16'h0, cfg});
        base = nsCount;
        for (int k = 0; k < 6; k++) begin
            phaseGenTick <= k < nPh;
            extRefTick <= k < nEx;
            step;
            @(posedge mclk);
        end
        repeat (3) @(posedge mclk);
        check(nsCount - base, inc);
    endtask

    task automatic giveVerdict;
        $display("Checks %0d errors %0d", testsRun, errCount);
        if (errCount == 0 && testsRun > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge mclk);
        errCount++;
        giveVerdict;
    end

    initial begin
        void'($urandom(32'h2508));
        lv = 12'($urandom);
        pinInputLevels <= lv;
        repeat (5) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        for (int i = 0; i < 8; i++) begin
            rdChk(adrTab[i], {16'h0, rstTab[i] | (i == 5 ? {4'h0, lv} : 16'h0)});
            wr(adrTab[i], 32'hffffffff);
            rdChk(adrTab[i], {16'h0, oneTab[i] | (i == 5 ? {4'h0, lv} : 16'h0)});
        end
        for (int v = 0; v < 10; v++) begin
            wr(ADR_REF_CLOCK, v);
            rdChk(ADR_REF_CLOCK, v < 8 ? 32'h8 : v);
        end
        for (int i = 0; i < 40; i++) begin
            sel = (i == 0) ? 12'h555 : 12'($urandom);
            p = (i == 0) ? 3'h7 : 3'($urandom);
            wr(ADR_SFD_ROUTE, {24'h0, sel[11:4]});
            wr(ADR_IRQ_ROUTE, {28'h0, sel[3:0]});
            {txSfdPulse, rxSfdPulse, ptpIrq} <= p;
            step;
            check(gpioOut, pinOf(sel[11:8], p[2]) | pinOf(sel[7:4], p[1]) | pinOf(sel[3:0], p[0]));
            @(posedge mclk);
        end
        t = 16'($urandom);
        wr(ADR_ETHERTYPE, {16'h0, t});
        for (int k = 0; k < 2; k++) begin
            frameTypeValid <= 1'b1;
            frameType <= t ^ 16'(k);
            step;
            check({31'h0, l2TypeMatch}, {31'h0, k == 0});
            @(posedge mclk);
        end
        h = 12'($urandom);
        for (int m = 0; m < 4; m++) begin
            wr(ADR_ID_FILTER, {19'h0, m[1], h});
            rxTsCandidate <= 1'b1;
            srcIdHash <= m[0] ? h : ~h;
            tsInsertReq <= 1'b1;
            step;
            check({rxTsDeliver, tsInsertGo}, {!m[1] || m[0], 1'b1});
            @(posedge mclk);
        end
        t = 16'($urandom);
        msgOffsetValid <= 1'b1;
        msgOffset <= t[7:0];
        step;
        @(posedge mclk);
        wr(ADR_MSG_OFFSET, 32'h0);
        rdChk(ADR_MSG_OFFSET, {24'h0, t[7:0]});
        tickRun(16'h0014, 4, 6, 32'd80);
        tickRun(16'h8019, 6, 3, 32'd75);
        tickRun(16'hc00a, 0, 2, 32'd20);
        tickRun(16'h4018, 6, 0, 32'd48);
        tickRun(16'h401f, 6, 0, 32'd62);
        tickRun(16'h400f, 6, 0, 32'd90);
        giveVerdict;
    end
endmodule // ptcr_bank_tb
